// file: logic/pmcc_pkg.sv
// Purpose: Shared constants for the power mode clock controller
// Assumes: 8-bit register port, 200 MHz mclk
// Notes: Offsets are word indices on the plain register port
package pmcc_pkg;
  localparam logic [1:0] PMCC_OFS_PMC = 2'h0;
  localparam logic [1:0] PMCC_OFS_PSAVE = 2'h1;
  localparam logic [1:0] PMCC_OFS_STAT = 2'h2;
  localparam logic [1:0] PMCC_OFS_OPT = 2'h3;
  localparam logic [7:0] PMCC_PMC_RST = 8'h40;
  localparam logic [7:0] PMCC_OPT_RST = 8'h01;
  localparam int PMCC_BIT_SLOW_ON = 7;
  localparam int PMCC_BIT_FAST_ON = 6;
  localparam int PMCC_BIT_DUAL = 5;
  localparam int PMCC_BIT_CORE = 4;
  localparam int PMCC_BIT_RSVD = 3;
  localparam int PMCC_BIT_HALT = 7;
  localparam int PMCC_BIT_IDLE = 6;
  localparam int PMCC_BIT_HALT_EN = 0;
  // Ordered legal upper nibbles
  localparam logic [3:0] PMCC_ST_HS = 4'h4;
  localparam logic [3:0] PMCC_ST_HS_DC = 4'hc;
  localparam logic [3:0] PMCC_ST_DC = 4'he;
  localparam logic [3:0] PMCC_ST_DC_LS = 4'hf;
  localparam logic [3:0] PMCC_ST_LS = 4'hb;
  localparam logic [2:0] PMCC_IDX_BAD = 3'h7;
  localparam logic [2:0] PMCC_WIN_MAX = 3'h4;
  localparam int PMCC_WIN_BASE_BIT = 12;
  localparam int PMCC_POWER_MODE_CONTROL_W = 17;
  localparam logic [8:0] PMCC_WAKE_LOAD = 9'h100;
  localparam logic [2:0] PMCC_INSTR_DIV = 3'h5;
  typedef enum logic [1:0] {PMCC_M_HS, PMCC_M_DC, PMCC_M_LS} pmcc_mode_t;
endpackage

// file: logic/pmcc_core_if.sv
// Purpose: Carrier between controller, timer and core clock switch
// Assumes: All signals on mclk
// Notes: Ticks are one-cycle pulses
`timescale 1ns/10ps
interface pmcc_core_if;
  logic tmr_tick;
  logic core_tick;
  logic load_wake;
  logic wake_done;
  logic [2:0] win_sel;
  logic win_hit;
  logic want_slow;
  logic core_gate;
  logic en_fast;
  logic en_slow;
  modport ctl (output tmr_tick, core_tick, load_wake, win_sel, want_slow, core_gate,
    input wake_done, win_hit, en_fast, en_slow);
  modport tmr (input tmr_tick, core_tick, load_wake, win_sel, output wake_done, win_hit);
  modport csw (input core_tick, want_slow, core_gate, output en_fast, en_slow);
endinterface

// file: logic/pmcc_idle_timer.sv
// Purpose: Free running idle timer, window tap and wake delay count
// Assumes: Ticks come from the controller
// Notes: Timer state after reset is not meaningful to software
`timescale 1ns/10ps
module pmcc_idle_timer
  import pmcc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Controller link
  pmcc_core_if.tmr tif
);
  import pmcc_pkg::*;
  logic [PMCC_POWER_MODE_CONTROL_W-1:0] cnt_ff, nxt_cnt;
  logic [8:0] wake_ff, nxt_wake;
  logic hit_ff, nxt_hit;
  logic done_ff, nxt_done;
  logic [2:0] sel;
  logic [PMCC_POWER_MODE_CONTROL_W-1:0] inc;

  always_comb begin
    sel = (tif.win_sel > PMCC_WIN_MAX) ? PMCC_WIN_MAX : tif.win_sel;
    inc = cnt_ff + 1'b1;
    nxt_cnt = cnt_ff;
    nxt_hit = 1'b0;
    nxt_wake = wake_ff;
    nxt_done = 1'b0;
    // Keeps counting in idle so real time survives
    if (tif.tmr_tick) begin
      nxt_cnt = inc;
      // Either edge of the tap bit closes a window
      nxt_hit = cnt_ff[PMCC_WIN_BASE_BIT + sel] ^ inc[PMCC_WIN_BASE_BIT + sel];
    end
    if (tif.load_wake) begin
      nxt_wake = PMCC_WAKE_LOAD;
    end else if (tif.core_tick && wake_ff != 9'h000) begin
      nxt_wake = wake_ff - 9'h001;
      nxt_done = (wake_ff == 9'h001);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
      hit_ff <= 1'b0;
      wake_ff <= 9'h000;
      done_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      hit_ff <= nxt_hit;
      wake_ff <= nxt_wake;
      done_ff <= nxt_done;
    end
  end

  assign tif.win_hit = hit_ff;
  assign tif.wake_done = done_ff;
endmodule

// file: logic/pmcc_core_clk_switch.sv
// Purpose: Break-before-make switch of the core clock source
// Assumes: Changes happen only on core ticks
// Notes: One dead tick between sources trades a little latency for no runt pulse
`timescale 1ns/10ps
module pmcc_core_clk_switch
  import pmcc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Controller link
  pmcc_core_if.csw cif
);
  import pmcc_pkg::*;
  typedef enum logic [1:0] {PMCC_CS_FAST, PMCC_CS_GAP, PMCC_CS_SLOW} pmcc_cs_t;
  pmcc_cs_t cs_ff, nxt_cs;
  logic ef_ff, nxt_ef;
  logic es_ff, nxt_es;

  always_comb begin
    nxt_cs = cs_ff;
    if (cif.core_tick) begin
      unique case (cs_ff)
        PMCC_CS_FAST: if (cif.want_slow) nxt_cs = PMCC_CS_GAP;
        PMCC_CS_SLOW: if (!cif.want_slow) nxt_cs = PMCC_CS_GAP;
        PMCC_CS_GAP: nxt_cs = cif.want_slow ? PMCC_CS_SLOW : PMCC_CS_FAST;
      endcase
    end
    nxt_ef = (nxt_cs == PMCC_CS_FAST) && cif.core_gate;
    nxt_es = (nxt_cs == PMCC_CS_SLOW) && cif.core_gate;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cs_ff <= PMCC_CS_FAST;
      ef_ff <= 1'b0;
      es_ff <= 1'b0;
    end else begin
      cs_ff <= nxt_cs;
      ef_ff <= nxt_ef;
      es_ff <= nxt_es;
    end
  end

  assign cif.en_fast = ef_ff;
  assign cif.en_slow = es_ff;
endmodule

// file: logic/pmcc_power_ctrl.sv
// Purpose: Power mode and clock mode controller with halt and idle sequencing
// Assumes: Slow oscillator arrives as a pin; wake events come from the wake-up block
// Notes: Register reads return data one cycle after the read strobe
// Functional notes
// - Three operating modes, each with halt and idle power-save states.
// - One option bit decides whether halt may be entered.
// - Idle stops execution; oscillator, idle timer and monitor keep running.
// - Halt and idle keep all state except the idle timer.
// - Reset loads the power mode control register with 40 hex.
// - Bit 7 turns the slow oscillator on or off.
// - Bit 6 turns the fast oscillator on or off.
// - Bit 5 picks the idle timer clock: fast at 0, slow at 1.
// - Bit 4 picks the core clock: fast at 0, slow at 1.
// - Bits 5 and 4 encode high speed, dual clock and low speed.
// - Bit 5 low with bit 4 high forces low speed.
// - Bits 2 to 0 select the idle timer window.
// - Upper nibble takes only the five ordered legal states.
// - A write jumping beyond a neighbouring state is ignored.
// - Every reset enters high speed mode.
// - Low speed cannot go straight to high speed.
// - High speed halt stops clocks and the fast oscillator pin.
// - Halt bit set halts in the middle of the next instruction cycle.
// - Halt ends on reset pin low or a wake-up event.
// - Idle bit set enters the idle state.
// - Reset exit from halt restarts execution at address zero.
// - Wake exit waits 256 instruction cycles before clocks return.
`timescale 1ns/10ps
module pmcc_power_ctrl
  import pmcc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register port
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Oscillators and wake-up
  input wire logic slow_osc_pin,
  input wire logic multi_input_wakeup,
  output logic slow_osc_on,
  output logic fast_osc_on,
  output logic main_osc_input_stop,
  // Core and idle timer clocking
  output logic core_clk_en_fast,
  output logic core_clk_en_slow,
  output logic idle_timer_clk_slow,
  output logic cpu_run,
  output logic cpu_restart_zero,
  output logic halted,
  output logic idling,
  output pmcc_pkg::pmcc_mode_t mode
);
  import pmcc_pkg::*;
  typedef enum logic [2:0] {
    PMCC_S_RUN, PMCC_S_HALT_PEND, PMCC_S_HALT, PMCC_S_WAKE, PMCC_S_IDLE
  } pmcc_state_t;

  // Shared wires to the two helper modules
  pmcc_core_if u_if();

  // Slow oscillator pin synchroniser
  logic s1_ff, s2_ff, s3_ff, lvl_ff, stick_ff;
  logic nxt_lvl, nxt_stick;

  // A level counts only once the last two flops agree, so one bad sample is lost
  always_comb begin
    nxt_lvl = lvl_ff;
    if (s2_ff == s3_ff) begin
      nxt_lvl = s3_ff;
    end
    nxt_stick = nxt_lvl & ~lvl_ff & slow_osc_on;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
      lvl_ff <= 1'b0;
      stick_ff <= 1'b0;
    end else begin
      s1_ff <= slow_osc_pin;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      lvl_ff <= nxt_lvl;
      stick_ff <= nxt_stick;
    end
  end

  // Fast instruction tick, only while the fast oscillator runs
  logic [2:0] div_ff, nxt_div;
  logic ftick_ff, nxt_ftick;

  always_comb begin
    nxt_div = div_ff;
    nxt_ftick = 1'b0;
    // Divider holds while the fast oscillator is stopped
    if (fast_osc_on) begin
      nxt_div = (div_ff == PMCC_INSTR_DIV - 3'h1) ? 3'h0 : div_ff + 3'h1;
      nxt_ftick = (div_ff == PMCC_INSTR_DIV - 3'h1);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      div_ff <= 3'h0;
      ftick_ff <= 1'b0;
    end else begin
      div_ff <= nxt_div;
      ftick_ff <= nxt_ftick;
    end
  end

  // Sequence position of an upper nibble, or illegal
  function automatic logic [2:0] pmcc_seq_idx(input logic [3:0] n);
    logic [2:0] idx;
    idx = PMCC_IDX_BAD;
    case (n)
      PMCC_ST_HS: idx = 3'h0;
      PMCC_ST_HS_DC: idx = 3'h1;
      PMCC_ST_DC: idx = 3'h2;
      PMCC_ST_DC_LS: idx = 3'h3;
      PMCC_ST_LS: idx = 3'h4;
      default: idx = PMCC_IDX_BAD;
    endcase
    return idx;
  endfunction

  // Register file
  logic [7:0] pmc_ff, nxt_pmc;
  logic opt_ff, nxt_opt;
  logic [7:0] rdata_ff, nxt_rdata;
  logic halt_req, idle_req;
  logic [2:0] cur_idx, new_idx;
  logic step_ok;
  logic [7:0] wr_pmc;
  logic [7:0] stat;
  pmcc_state_t st_ff, nxt_st;

  always_comb begin
    nxt_pmc = pmc_ff;
    nxt_opt = opt_ff;
    halt_req = 1'b0;
    idle_req = 1'b0;
    wr_pmc = reg_wdata;
    // Reserved bit never stored, whatever software writes
    wr_pmc[PMCC_BIT_RSVD] = 1'b0;
    cur_idx = pmcc_seq_idx(pmc_ff[7:4]);
    new_idx = pmcc_seq_idx(wr_pmc[7:4]);
    // Same or adjacent legal state only; blocks low speed to high speed
    step_ok = (new_idx != PMCC_IDX_BAD) &&
              (new_idx == cur_idx || new_idx == cur_idx + 3'h1 ||
               new_idx + 3'h1 == cur_idx);
    if (reg_wr) begin
      unique case (reg_addr)
        PMCC_OFS_PMC: begin
          if (step_ok) begin
            nxt_pmc = wr_pmc;
          end else begin
            // Refused write leaves every bit as it was, window field too
            nxt_pmc = pmc_ff;
          end
        end
        PMCC_OFS_PSAVE: begin
          // Halt wins over idle when both are asked for and the option bit allows halt
          halt_req = reg_wdata[PMCC_BIT_HALT] & opt_ff;
          idle_req = reg_wdata[PMCC_BIT_IDLE];
        end
        // Option bit 0 gates halt entry
        PMCC_OFS_OPT: nxt_opt = reg_wdata[PMCC_BIT_HALT_EN];
        PMCC_OFS_STAT: nxt_opt = opt_ff;
      endcase
    end
  end

  always_comb begin
    // Status word; bit 5 shows the synchronised slow pin
    stat = 8'h00;
    stat[0] = (st_ff == PMCC_S_HALT);
    stat[1] = (st_ff == PMCC_S_IDLE);
    stat[2] = (st_ff == PMCC_S_WAKE);
    stat[3] = u_if.en_fast;
    stat[4] = u_if.en_slow;
    stat[5] = lvl_ff;
    stat[7:6] = mode;
    // Read data are zero outside the cycle after a read
    nxt_rdata = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        PMCC_OFS_PMC: nxt_rdata = pmc_ff;
        PMCC_OFS_PSAVE: nxt_rdata = {stat[0], stat[1], 6'h00};
        PMCC_OFS_STAT: nxt_rdata = stat;
        PMCC_OFS_OPT: nxt_rdata = {7'h00, opt_ff};
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pmc_ff <= PMCC_PMC_RST;
      opt_ff <= PMCC_OPT_RST[PMCC_BIT_HALT_EN];
      rdata_ff <= 8'h00;
    end else begin
      pmc_ff <= nxt_pmc;
      opt_ff <= nxt_opt;
      rdata_ff <= nxt_rdata;
    end
  end

  // Mode decode; the invalid pair falls to low speed
  pmcc_mode_t mode_d;
  always_comb begin
    unique case (pmc_ff[PMCC_BIT_DUAL -: 2])
      2'b00: mode_d = PMCC_M_HS;
      2'b10: mode_d = PMCC_M_DC;
      2'b11: mode_d = PMCC_M_LS;
      2'b01: mode_d = PMCC_M_LS;
    endcase
  end

  // Power-save sequencing; execution stops but no state is touched
  logic boot_ff, nxt_boot;
  logic run_ff, nxt_run;
  logic restart_ff, nxt_restart;
  logic fon_ff, nxt_fon;
  logic son_ff, nxt_son;
  logic stop_ff, nxt_stop;
  logic itslow_ff, nxt_itslow;
  logic halted_ff, nxt_halted;
  logic idling_ff, nxt_idling;
  pmcc_mode_t mode_ff;
  logic load_wake;

  always_comb begin
    nxt_st = st_ff;
    load_wake = 1'b0;
    // Boot flag marks the first edge out of reset for the restart pulse
    nxt_boot = 1'b1;
    nxt_restart = ~boot_ff;
    unique case (st_ff)
      PMCC_S_RUN: begin
        if (halt_req) begin
          nxt_st = PMCC_S_HALT_PEND;
        end else if (idle_req) begin
          nxt_st = PMCC_S_IDLE;
        end
      end
      // Stops mid way into the next instruction cycle
      PMCC_S_HALT_PEND: if (u_if.core_tick) nxt_st = PMCC_S_HALT;
      PMCC_S_HALT: begin
        if (multi_input_wakeup) begin
          // Wake counter restarts from full on every wake exit
          nxt_st = PMCC_S_WAKE;
          load_wake = 1'b1;
        end
      end
      // Clocks return only after the full count, so the oscillator can settle
      PMCC_S_WAKE: if (u_if.wake_done) nxt_st = PMCC_S_RUN;
      PMCC_S_IDLE: begin
        // Window hit or wake event, whichever comes first
        if (u_if.win_hit || multi_input_wakeup) nxt_st = PMCC_S_RUN;
      end
    endcase
    nxt_run = boot_ff && (nxt_st == PMCC_S_RUN || nxt_st == PMCC_S_HALT_PEND);
    nxt_son = pmc_ff[PMCC_BIT_SLOW_ON];
    // Fast oscillator pin held still in high speed halt
    nxt_stop = (nxt_st == PMCC_S_HALT) && (mode_d == PMCC_M_HS);
    nxt_fon = pmc_ff[PMCC_BIT_FAST_ON] && !nxt_stop;
    nxt_itslow = pmc_ff[PMCC_BIT_DUAL];
    // The wake delay still counts as halted to the core
    nxt_halted = (nxt_st == PMCC_S_HALT) || (nxt_st == PMCC_S_WAKE);
    nxt_idling = (nxt_st == PMCC_S_IDLE);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= PMCC_S_RUN;
      boot_ff <= 1'b0;
      run_ff <= 1'b0;
      restart_ff <= 1'b0;
      fon_ff <= PMCC_PMC_RST[PMCC_BIT_FAST_ON];
      son_ff <= PMCC_PMC_RST[PMCC_BIT_SLOW_ON];
      stop_ff <= 1'b0;
      itslow_ff <= PMCC_PMC_RST[PMCC_BIT_DUAL];
      halted_ff <= 1'b0;
      idling_ff <= 1'b0;
      mode_ff <= PMCC_M_HS;
    end else begin
      st_ff <= nxt_st;
      boot_ff <= nxt_boot;
      run_ff <= nxt_run;
      restart_ff <= nxt_restart;
      fon_ff <= nxt_fon;
      son_ff <= nxt_son;
      stop_ff <= nxt_stop;
      itslow_ff <= nxt_itslow;
      halted_ff <= nxt_halted;
      idling_ff <= nxt_idling;
      mode_ff <= mode_d;
    end
  end

  // Links to the timer and the core clock switch
  assign u_if.tmr_tick = itslow_ff ? stick_ff : ftick_ff;
  // Tick source follows the select bit at once; the switch supplies the gap
  assign u_if.core_tick = pmc_ff[PMCC_BIT_CORE] ? stick_ff : ftick_ff;
  assign u_if.load_wake = load_wake;
  assign u_if.win_sel = pmc_ff[2:0];
  assign u_if.want_slow = (mode_d == PMCC_M_LS);
  assign u_if.core_gate = run_ff;

  pmcc_idle_timer u_tmr (
    .mclk(mclk),
    .rst_n(rst_n),
    .tif(u_if.tmr)
  );

  pmcc_core_clk_switch u_csw (
    .mclk(mclk),
    .rst_n(rst_n),
    .cif(u_if.csw)
  );

  assign reg_rdata = rdata_ff;
  assign slow_osc_on = son_ff;
  assign fast_osc_on = fon_ff;
  assign main_osc_input_stop = stop_ff;
  assign core_clk_en_fast = u_if.en_fast;
  assign core_clk_en_slow = u_if.en_slow;
  assign idle_timer_clk_slow = itslow_ff;
  assign cpu_run = run_ff;
  assign cpu_restart_zero = restart_ff;
  assign halted = halted_ff;
  assign idling = idling_ff;
  assign mode = mode_ff;
endmodule

// file: tb/pmcc_power_chk.sv
// Purpose: Port checks for the power mode clock controller
// Assumes: Bound to every pmcc_power_ctrl instance
// Notes: Wake bound holds for high speed halt only, slow ticks are far longer
`timescale 1ns/10ps
module pmcc_power_chk
  import pmcc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Watched signals
  input wire logic multi_input_wakeup,
  input wire logic slow_osc_on,
  input wire logic fast_osc_on,
  input wire logic main_osc_input_stop,
  input wire logic core_clk_en_fast,
  input wire logic core_clk_en_slow,
  input wire logic cpu_run,
  input wire logic cpu_restart_zero,
  input wire logic halted,
  input wire logic idling,
  input wire pmcc_pkg::pmcc_mode_t mode
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_one_src; !(core_clk_en_fast && core_clk_en_slow); endproperty
  a_one_src: assert property (p_one_src) else $error("both core enables high");
  // Cycles from a high speed wake event until halted falls
  localparam int WAKE_MIN = 1249;
  localparam int WAKE_MAX = 1409;
  logic wake_arm_ff;
  logic [10:0] wake_cyc_ff;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wake_arm_ff <= 1'b0;
      wake_cyc_ff <= 11'h000;
    end else if (main_osc_input_stop && multi_input_wakeup) begin
      wake_arm_ff <= 1'b1;
      wake_cyc_ff <= 11'h000;
    end else if (wake_arm_ff && halted) begin
      wake_cyc_ff <= wake_cyc_ff + 11'h001;
    end else begin
      wake_arm_ff <= 1'b0;
    end
  end
  property p_wake; wake_arm_ff && $fell(halted) |-> wake_cyc_ff >= WAKE_MIN; endproperty
  a_wake: assert property (p_wake) else $error("wake delay too short");
  property p_wake_max; wake_arm_ff && halted |-> wake_cyc_ff <= WAKE_MAX; endproperty
  a_wake_max: assert property (p_wake_max) else $error("wake delay too long");
  property p_idle; idling |-> !cpu_run && !halted; endproperty
  a_idle: assert property (p_idle) else $error("running while idle");
  property p_halt; $rose(halted) |-> !cpu_run; endproperty
  a_halt: assert property (p_halt) else $error("running while halted");
  property p_restart; cpu_restart_zero |-> !cpu_run ##1 (cpu_run && !cpu_restart_zero); endproperty
  a_restart: assert property (p_restart) else $error("restart pulse wrong");
  property p_stop; main_osc_input_stop |-> mode == PMCC_M_HS && !cpu_run; endproperty
  a_stop: assert property (p_stop) else $error("osc stop outside halt");
  property p_dc_osc; mode == PMCC_M_DC |-> slow_osc_on && fast_osc_on; endproperty
  a_dc_osc: assert property (p_dc_osc) else $error("dual clock osc off");
  property p_ls_slow; mode == PMCC_M_LS |-> slow_osc_on; endproperty
  a_ls_slow: assert property (p_ls_slow) else $error("low speed without slow osc");
  property p_hs_fast;
    mode == PMCC_M_HS && !halted && !main_osc_input_stop |-> fast_osc_on;
  endproperty
  a_hs_fast: assert property (p_hs_fast) else $error("high speed without fast osc");
endmodule

bind pmcc_power_ctrl pmcc_power_chk u_chk (
  .mclk(mclk), .rst_n(rst_n), .multi_input_wakeup(multi_input_wakeup),
  .slow_osc_on(slow_osc_on), .fast_osc_on(fast_osc_on),
  .main_osc_input_stop(main_osc_input_stop), .core_clk_en_fast(core_clk_en_fast),
  .core_clk_en_slow(core_clk_en_slow), .cpu_run(cpu_run),
  .cpu_restart_zero(cpu_restart_zero), .halted(halted), .idling(idling), .mode(mode));

// file: tb/test_power_mode_clock_control.sv
// Purpose: Self-checking bench for the power mode clock controller
// Assumes: Register port with read data one cycle after the strobe
// Notes: Mode walk model is kept as integers beside the design
`timescale 1ns/10ps
module test_power_mode_clock_control;
  import pmcc_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic multi_input_wakeup = 1'b0;
  logic [3:0] sdiv = 4'h0;
  logic slow_osc_on, fast_osc_on, main_osc_input_stop, core_clk_en_fast, core_clk_en_slow;
  logic idle_timer_clk_slow, cpu_run, cpu_restart_zero, halted, idling;
  pmcc_mode_t mode;
  int err_total = 0;
  int checks_done = 0;
  logic [31:0] seed = 32'hfbc9bd32;
  logic [7:0] d;
  int pmc_m;
  int n;
  int st [5] = '{4, 12, 14, 15, 11};
  pmcc_power_ctrl DUT (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .slow_osc_pin(sdiv[3]), .multi_input_wakeup(multi_input_wakeup),
    .slow_osc_on(slow_osc_on), .fast_osc_on(fast_osc_on),
    .main_osc_input_stop(main_osc_input_stop), .core_clk_en_fast(core_clk_en_fast),
    .core_clk_en_slow(core_clk_en_slow), .idle_timer_clk_slow(idle_timer_clk_slow),
    .cpu_run(cpu_run), .cpu_restart_zero(cpu_restart_zero), .halted(halted),
    .idling(idling), .mode(mode));
  initial begin
    forever #2.5 mclk = ~mclk;
  end
  // Slow pin runs free, one period per 16 mclk
  always @(posedge mclk) sdiv <= sdiv + 4'h1;
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic int idx(input int nib);
    for (int i = 0; i < 5; i++) begin
      if (st[i] == nib) return i;
    end
    return 9;
  endfunction
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, output logic [7:0] v);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    #1 chk("restart", {7'h0, cpu_restart_zero}, 8'h01);
    chk("run", {7'h0, cpu_run}, 8'h00);
    @(posedge mclk);
    #1 chk("restart end", {7'h0, cpu_restart_zero}, 8'h00);
    chk("run", {7'h0, cpu_run}, 8'h01);
  endtask
  task automatic wait_for(ref logic s, input logic lvl, input int lim);
    #1;
    n = 0;
    while (s !== lvl && n < lim) begin
      @(posedge mclk);
      #1 n++;
    end
    chk("wait", {7'h0, s}, {7'h0, lvl});
  endtask
  task automatic wake();
    @(posedge mclk);
    multi_input_wakeup <= 1'b1;
    @(posedge mclk);
    multi_input_wakeup <= 1'b0;
  endtask
  task automatic print_verdict();
    if (err_total == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #(5ns * 40000);
    err_total++;
    print_verdict();
  end
  initial begin
    do_reset();
    rd(PMCC_OFS_PMC, d);
    chk("pmc rst", d, PMCC_PMC_RST);
    rd(PMCC_OFS_OPT, d);
    chk("opt rst", d, PMCC_OPT_RST);
    chk("osc rst", {6'h0, slow_osc_on, fast_osc_on}, 8'h01);
    // Status is read-only, slow pin level masked
    wr(PMCC_OFS_STAT, 8'hff);
    rd(PMCC_OFS_STAT, d);
    chk("status", d & 8'hdf, 8'h08);
    // Halt refused while the option bit is clear
    wr(PMCC_OFS_OPT, 8'h00);
    wr(PMCC_OFS_PSAVE, 8'h80);
    repeat (20) @(posedge mclk);
    #1 chk("halt off", {7'h0, halted}, 8'h00);
    wr(PMCC_OFS_OPT, 8'h01);
    wr(PMCC_OFS_PSAVE, 8'h80);
    wait_for(halted, 1'b1, 20);
    chk("hs halt", {6'h0, main_osc_input_stop, fast_osc_on}, 8'h02);
    rd(PMCC_OFS_PMC, d);
    chk("pmc kept", d, 8'h40);
    wake();
    wait_for(cpu_run, 1'b1, 1500);
    chk("wake len", {7'h0, n > 1200}, 8'h01);
    wr(PMCC_OFS_PSAVE, 8'h40);
    wait_for(idling, 1'b1, 10);
    wake();
    wait_for(idling, 1'b0, 20);
    // Idle ends by itself at the next toggle of the 4k window tap
    wr(PMCC_OFS_PSAVE, 8'h40);
    wait_for(idling, 1'b1, 10);
    wait_for(idling, 1'b0, 21000);
    // Reset ends a halt and restores high speed
    wr(PMCC_OFS_PSAVE, 8'h80);
    wait_for(halted, 1'b1, 20);
    do_reset();
    chk("halt end", {7'h0, halted}, 8'h00);
    // Round trip to low speed in legal steps, each oscillator settled first
    wr(PMCC_OFS_PMC, 8'hc0);
    repeat (40) @(posedge mclk);
    wr(PMCC_OFS_PMC, 8'he0);
    repeat (4) @(posedge mclk);
    #1 chk("dc mode", 8'(mode), 8'h01);
    wr(PMCC_OFS_PMC, 8'hf0);
    wr(PMCC_OFS_PMC, 8'hb0);
    repeat (80) @(posedge mclk);
    #1 chk("ls mode", 8'(mode), 8'h02);
    chk("ls core", {6'h0, core_clk_en_fast, core_clk_en_slow}, 8'h01);
    wr(PMCC_OFS_PMC, 8'hf0);
    repeat (40) @(posedge mclk);
    wr(PMCC_OFS_PMC, 8'he0);
    wr(PMCC_OFS_PMC, 8'hc0);
    wr(PMCC_OFS_PMC, 8'h40);
    repeat (20) @(posedge mclk);
    #1 chk("hs core", {6'h0, core_clk_en_fast, core_clk_en_slow}, 8'h02);
    chk("hs mode", 8'(mode), 8'h00);
    pmc_m = 'h40;
    for (int k = 0; k < 60; k++) begin
      int nib;
      int oi;
      seed = xs(seed);
      nib = seed[8] ? int'(seed[7:4]) : st[seed[31:16] % 5];
      wr(PMCC_OFS_PMC, {nib[3:0], 1'b0, seed[2:0]});
      oi = idx(pmc_m >> 4);
      if (idx(nib) < 9 && idx(nib) - oi <= 1 && oi - idx(nib) <= 1) begin
        pmc_m = (nib << 4) | int'(seed[2:0]);
      end
      rd(PMCC_OFS_PMC, d);
      chk("pmc", d, 8'(pmc_m));
      chk("slow", {7'h0, slow_osc_on}, 8'(pmc_m >> 7));
      chk("fast", {7'h0, fast_osc_on}, 8'((pmc_m >> 6) & 1));
      chk("itclk", {7'h0, idle_timer_clk_slow}, 8'((pmc_m >> 5) & 1));
      n = (pmc_m >> 4) & 3;
      chk("mode", 8'(mode), (n == 0) ? 8'h00 : (n == 2) ? 8'h01 : 8'h02);
    end
    print_verdict();
  end
endmodule
